/* File: verilog/trs_sequencer.sv */
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module trs_sequencer
  import trs_pkg::*;
#(
  parameter int unsigned SETUP_CNT = SETUP_CYCLES,
  parameter int unsigned TICK_CNT  = DELAY_TICK_CYCLES,
  parameter int unsigned RDG_W     = 32
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Register port
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [31:0]      rdata,
  // Measurement path
  input  wire logic             ext_trig_pin,
  input  wire logic             local_mode,
  input  wire logic             local_trig,
  input  wire logic [15:0]      auto_delay_ticks,
  input  wire logic             rdg_valid,
  input  wire logic [RDG_W-1:0] rdg_data,
  input  wire logic             self_test_done,
  input  wire logic             self_test_fail,
  output logic                  sample_req,
  output logic                  zero_req,
  output logic                  self_test_start,
  output logic                  math_valid,
  output logic      [RDG_W-1:0] math_data,
  // Output buffer and panel
  output logic                  out_valid,
  output logic      [RDG_W-1:0] out_data,
  output logic                  beep_enable,
  output logic      [4:0]       power_reference_resistance,
  output logic      [3:0]       panel_message_len
);

  typedef struct packed {
    trs_state_t  st;
    trs_src_t    src;
    logic [15:0] samples;
    logic [15:0] trigs;
    logic        trig_inf;
    logic [25:0] delay;
    logic        auto_delay;
    logic        feed_calc;
    logic        to_out;
    logic        zero_off;
    logic        zero_due;
    logic [31:0] setup_cnt;
    logic [25:0] dly_cnt;
    logic [15:0] tick_cnt;
    logic [15:0] smp_left;
    logic [15:0] trg_left;
    logic [9:0]  points;
    logic [9:0]  rd_ptr;
    logic [4:0]  err_head;
    logic [4:0]  err_tail;
    logic [4:0]  err_cnt;
    logic [31:0] lim_lo;
    logic [31:0] lim_hi;
    logic [31:0] high_range;
    logic [4:0]  pwr_ref;
    logic        beep;
    logic [3:0]  msg_len;
    logic        st_busy;
    logic        st_result;
    logic        st_start;
    logic        sample_req;
    logic        zero_req;
    logic        mem_we;
    logic [8:0]  mem_wa;
    logic        err_we;
    logic [7:0]  err_code;
    logic        out_valid;
    logic [RDG_W-1:0] out_data;
    logic        math_valid;
    logic [RDG_W-1:0] math_data;
    logic [31:0] rdata;
  } trs_regs_t;

  trs_regs_t r;
  trs_regs_t next_r;

  logic [RDG_W-1:0] mem [MEM_DEPTH];
  logic [7:0]       errq [ERR_DEPTH];
  logic             ext_s1;
  logic             ext_s2;
  logic             ext_s3;
  logic             ext_edge;
  logic             trig_hit;

  // Pin crosses into mclk through two flops before edge detect
  always_ff @(posedge mclk)
  begin
    ext_s1 <= ext_trig_pin;
    ext_s2 <= ext_s1;
    ext_s3 <= ext_s2;
  end
  assign ext_edge = ext_s2 & ~ext_s3;

  function automatic logic [4:0] err_inc(input logic [4:0] p);
    err_inc = (p == 5'(ERR_DEPTH - 1)) ? 5'h00 : p + 5'h01;
  endfunction

  function automatic logic [15:0] clamp_cnt(input logic [31:0] v);
    if (v[31:16] != 16'h0000 || v[15:0] > COUNT_MAX)
      clamp_cnt = COUNT_MAX;
    else if (v[15:0] < COUNT_MIN)
      clamp_cnt = COUNT_MIN;
    else
      clamp_cnt = v[15:0];
  endfunction

  // Signed bound within plus/minus 120 percent of the highest range
  function automatic logic in_limit(input logic [31:0] v, input logic [31:0] hr);
    logic signed [35:0] lim;
    logic signed [35:0] sv;
    lim = 36'(signed'({1'b0, hr})) + 36'(signed'({1'b0, hr})) / 36'sd5;
    sv = 36'(signed'(v));
    in_limit = (sv <= lim) && (sv >= -lim);
  endfunction

  always_comb
  begin
    logic       cmd;
    logic [3:0] cl;
    next_r = r;
    cmd = wr && (addr == A_CMD);
    cl = 4'h0;
    next_r.sample_req = 1'b0;
    next_r.zero_req = 1'b0;
    next_r.st_start = 1'b0;
    next_r.mem_we = 1'b0;
    next_r.err_we = 1'b0;
    next_r.out_valid = 1'b0;
    next_r.math_valid = 1'b0;
    next_r.rdata = 32'h0000_0000;
    trig_hit = 1'b0;
    if (rdg_valid)
    begin
      next_r.math_valid = 1'b1;
      next_r.math_data = rdg_data;
    end

    // Configuration writes
    if (wr)
    begin
      if (addr == A_TRIG_SRC)
        next_r.src = (wdata[1:0] == 2'h1) ? SRC_BUS : (wdata[1:0] == 2'h2) ? SRC_EXT : SRC_IMM;
      else if (addr == A_SAMPLES)
        next_r.samples = clamp_cnt(wdata);
      else if (addr == A_TRIGS)
      begin
        next_r.trig_inf = wdata[31];
        next_r.trigs = clamp_cnt({1'b0, wdata[30:0]});
      end
      else if (addr == A_DELAY)
      begin
        next_r.delay = (wdata[25:0] > DELAY_MAX_TICKS) ? DELAY_MAX_TICKS : wdata[25:0];
        next_r.auto_delay = 1'b0;
      end
      else if (addr == A_AUTO_DELAY)
        next_r.auto_delay = wdata[0];
      else if (addr == A_FEED)
        next_r.feed_calc = wdata[0];
      else if (addr == A_MSG_LEN)
        next_r.msg_len = (wdata > 32'(MSG_CHARS)) ? 4'(MSG_CHARS) : wdata[3:0];
      else if (addr == A_HIGH_RANGE)
        next_r.high_range = wdata;
      else if (addr == A_LIM_LO || addr == A_LIM_HI)
      begin
        if (in_limit(wdata, r.high_range))
        begin
          if (addr == A_LIM_LO)
            next_r.lim_lo = wdata;
          else
            next_r.lim_hi = wdata;
        end
        else
          cl = 4'h3;
      end
      else if (addr == A_PWR_REF)
      begin
        if (wdata[4:0] < REF_COUNT)
          next_r.pwr_ref = wdata[4:0];
        else
          cl = 4'h3;
      end
      else if (addr == A_BEEP)
        next_r.beep = wdata[0];
      else if (addr == A_ZERO)
        next_r.zero_off = wdata[0];
    end

    if (cmd && (wdata[CMD_ONE_SHOT] || wdata[CMD_CONFIGURE]))
      next_r.feed_calc = 1'b1;

    if (cmd && wdata[CMD_SELF_TEST] && !r.st_busy)
    begin
      next_r.st_start = 1'b1;
      next_r.st_busy = 1'b1;
    end
    if (self_test_done && r.st_busy)
    begin
      next_r.st_busy = 1'b0;
      next_r.st_result = self_test_fail;
    end

    // Device clear leaves any state, infinite runs included
    if (cmd && wdata[CMD_CLEAR])
      next_r.st = ST_IDLE;
    else
      case (r.st)
        ST_IDLE:
        begin
          if (cmd && (wdata[CMD_ARM_STORE] || wdata[CMD_ARM_RETURN] || wdata[CMD_ONE_SHOT]))
          begin
            next_r.st = ST_SETUP;
            next_r.to_out = wdata[CMD_ARM_RETURN];
            next_r.setup_cnt = 32'(SETUP_CNT);
            next_r.trg_left = r.trigs;
            next_r.zero_req = r.zero_off;
            if (!wdata[CMD_ARM_RETURN])
              next_r.points = 10'h000;
          end
          else if (cmd && wdata[CMD_FETCH])
          begin
            if (!r.feed_calc)
              cl = 4'h1;
            else
            begin
              next_r.st = ST_DUMP;
              next_r.rd_ptr = 10'h000;
            end
          end
          else if (local_mode && local_trig)
          begin
            trig_hit = 1'b1;
            next_r.to_out = 1'b1;
            next_r.trg_left = COUNT_MIN;
          end
        end
        ST_SETUP:
        begin
          // External edges here are simply not looked at
          if (r.setup_cnt <= 32'h1)
            next_r.st = ST_WAIT;
          else
            next_r.setup_cnt = r.setup_cnt - 32'h1;
        end
        ST_WAIT:
        begin
          case (r.src)
            SRC_IMM: trig_hit = 1'b1;
            SRC_BUS: trig_hit = cmd && wdata[CMD_BUS_TRIG];
            default: trig_hit = ext_edge;
          endcase
        end
        ST_DELAY:
        begin
          if (r.dly_cnt == 26'h0)
          begin
            next_r.st = ST_SAMPLE;
            next_r.sample_req = 1'b1;
          end
          else if (r.tick_cnt == 16'h0)
          begin
            next_r.tick_cnt = 16'(TICK_CNT - 1);
            next_r.dly_cnt = r.dly_cnt - 26'h1;
          end
          else
            next_r.tick_cnt = r.tick_cnt - 16'h1;
        end
        ST_SAMPLE:
        begin
          if (rdg_valid)
          begin
            if (r.to_out)
            begin
              next_r.out_valid = 1'b1;
              next_r.out_data = rdg_data;
            end
            else if (r.feed_calc)
            begin
              if (r.points == 10'(MEM_DEPTH))
                cl = 4'h2;
              else
              begin
                next_r.mem_we = 1'b1;
                next_r.mem_wa = r.points[8:0];
                next_r.points = r.points + 10'h001;
              end
            end
            next_r.dly_cnt = r.auto_delay ? 26'(auto_delay_ticks) : r.delay;
            next_r.tick_cnt = 16'(TICK_CNT - 1);
            if (r.smp_left > 16'h1)
            begin
              next_r.smp_left = r.smp_left - 16'h1;
              next_r.st = ST_DELAY;
            end
            else if (r.trig_inf && !local_mode)
              next_r.st = ST_WAIT;
            else if (r.trg_left > 16'h1 && !local_mode)
            begin
              next_r.trg_left = r.trg_left - 16'h1;
              next_r.st = ST_WAIT;
            end
            else
              next_r.st = ST_IDLE;
          end
        end
        ST_DUMP:
        begin
          if (r.rd_ptr == r.points)
            next_r.st = ST_IDLE;
          else
          begin
            next_r.out_valid = 1'b1;
            next_r.out_data = mem[r.rd_ptr[8:0]];
            next_r.rd_ptr = r.rd_ptr + 10'h001;
          end
        end
        default: next_r.st = ST_IDLE;
      endcase

    if (trig_hit)
    begin
      next_r.st = ST_DELAY;
      next_r.smp_left = r.samples;
      next_r.dly_cnt = r.auto_delay ? 26'(auto_delay_ticks) : r.delay;
      next_r.tick_cnt = 16'(TICK_CNT - 1);
    end

    // Error queue; a full queue drops the newest entry
    if (rd && addr == A_ERR && r.err_cnt != 5'h0)
    begin
      next_r.err_head = err_inc(r.err_head);
      next_r.err_cnt = r.err_cnt - 5'h1;
    end
    if (cl != 4'h0 && next_r.err_cnt < 5'(ERR_DEPTH))
    begin
      next_r.err_we = 1'b1;
      next_r.err_code = (cl == 4'h1) ? ERR_NO_STORAGE : (cl == 4'h2) ? ERR_OVERFLOW : ERR_RANGE;
      next_r.err_tail = err_inc(r.err_tail);
      next_r.err_cnt = next_r.err_cnt + 5'h1;
    end

    if (rd)
    begin
      if (addr == A_TRIG_SRC)
        next_r.rdata = {30'h0, r.src};
      else if (addr == A_SAMPLES)
        next_r.rdata = {16'h0, r.samples};
      else if (addr == A_TRIGS)
        next_r.rdata = {r.trig_inf, 15'h0, r.trigs};
      else if (addr == A_DELAY)
        next_r.rdata = {6'h0, r.delay};
      else if (addr == A_AUTO_DELAY)
        next_r.rdata = {31'h0, r.auto_delay};
      else if (addr == A_FEED)
        next_r.rdata = {31'h0, r.feed_calc};
      else if (addr == A_STATUS)
        next_r.rdata = {24'h0, r.st_busy, r.st_result, r.to_out, 2'h0, r.st};
      else if (addr == A_POINTS)
        next_r.rdata = {22'h0, r.points};
      else if (addr == A_ERR)
        next_r.rdata = (r.err_cnt == 5'h0) ? 32'h0 : {19'h0, r.err_cnt, errq[r.err_head]};
      else if (addr == A_MSG_LEN)
        next_r.rdata = {28'h0, r.msg_len};
      else if (addr == A_LIM_LO)
        next_r.rdata = r.lim_lo;
      else if (addr == A_LIM_HI)
        next_r.rdata = r.lim_hi;
      else if (addr == A_HIGH_RANGE)
        next_r.rdata = r.high_range;
      else if (addr == A_PWR_REF)
        next_r.rdata = {27'h0, r.pwr_ref};
      else if (addr == A_BEEP)
        next_r.rdata = {31'h0, r.beep};
      else if (addr == A_SELFTEST)
        next_r.rdata = {30'h0, r.st_busy, r.st_result};
      else if (addr == A_ZERO)
        next_r.rdata = {31'h0, r.zero_off};
      else
        next_r.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.src <= SRC_IMM;
      r.samples <= COUNT_MIN;
      r.trigs <= COUNT_MIN;
      r.auto_delay <= 1'b1;
      r.feed_calc <= 1'b1;
      r.pwr_ref <= REF_DEFAULT;
      r.beep <= 1'b1;
      r.msg_len <= 4'h0;
    end
    else
      r <= next_r;
  end

  // Memory arrays carry no reset; writes lag the struct by a cycle
  always_ff @(posedge mclk)
  begin
    if (r.mem_we)
      mem[r.mem_wa] <= r.math_data;
    if (r.err_we)
      errq[(r.err_tail == 5'h0) ? 5'(ERR_DEPTH - 1) : r.err_tail - 5'h1] <= r.err_code;
  end

  assign rdata = r.rdata;
  assign sample_req = r.sample_req;
  assign zero_req = r.zero_req;
  assign self_test_start = r.st_start;
  assign math_valid = r.math_valid;
  assign math_data = r.math_data;
  assign out_valid = r.out_valid;
  assign out_data = r.out_data;
  assign beep_enable = r.beep;
  assign power_reference_resistance = r.pwr_ref;
  assign panel_message_len = r.msg_len;

endmodule
`default_nettype wire

/* File: verilog/trs_pkg.sv */
// Overview of operation
// - Bus and external triggers ignored unless armed and waiting
// - External triggers dropped during 20 ms setup
// - Trigger source: bus, immediate, external
// - Samples per trigger 1 to 50000
// - Trigger count 1 to 50000, then idle
// - Infinite count runs until device clear
// - Delay 0 to 3600 s before each sample
// - Auto delay from setup; explicit clears auto
// - Armed-and-stored readings go to 512-entry memory
// - Storage disabled: memory skipped, math still sees
// - Fetch with storage disabled logs an error
// - One-shot and configure re-enable storage
// - Arm-and-return sends readings to output directly
// - Fetch copies all stored readings out
// - Point count reports stored readings
// - Error FIFO of 20 entries, oldest first
// - Panel message keeps twelve characters only
// - Limit bounds within plus/minus 120 percent
// - Power reference one of seventeen, default 600
// - Beeper enable retained, suppresses event tones
// - Self-test reports 0 pass, 1 fail
// - Local mode always armed unless measuring
// - Autozero off: zero again on next arm
package trs_pkg;

  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned SETUP_MS      = 20;
  localparam int unsigned SETUP_CYCLES  = SETUP_MS * (CLK_HZ / 1000);
  localparam int unsigned DELAY_UNIT_US = 100;
  localparam int unsigned DELAY_TICK_CYCLES = DELAY_UNIT_US * (CLK_HZ / 1_000_000);
  localparam logic [25:0] DELAY_MAX_TICKS = 26'h2255100;
  localparam logic [15:0] COUNT_MAX     = 16'hC350;
  localparam logic [15:0] COUNT_MIN     = 16'h0001;
  localparam int unsigned MEM_DEPTH     = 512;
  localparam int unsigned ERR_DEPTH     = 20;
  localparam int unsigned ERR_CHARS     = 80;
  localparam int unsigned MSG_CHARS     = 12;
  localparam logic [4:0]  REF_DEFAULT   = 5'h0B;
  localparam logic [4:0]  REF_COUNT     = 5'h11;

  localparam logic [7:0] A_TRIG_SRC   = 8'h00;
  localparam logic [7:0] A_SAMPLES    = 8'h04;
  localparam logic [7:0] A_TRIGS      = 8'h08;
  localparam logic [7:0] A_DELAY      = 8'h0C;
  localparam logic [7:0] A_AUTO_DELAY = 8'h10;
  localparam logic [7:0] A_FEED       = 8'h14;
  localparam logic [7:0] A_CMD        = 8'h18;
  localparam logic [7:0] A_STATUS     = 8'h1C;
  localparam logic [7:0] A_POINTS     = 8'h20;
  localparam logic [7:0] A_ERR        = 8'h24;
  localparam logic [7:0] A_MSG_LEN    = 8'h28;
  localparam logic [7:0] A_LIM_LO     = 8'h2C;
  localparam logic [7:0] A_LIM_HI     = 8'h30;
  localparam logic [7:0] A_HIGH_RANGE = 8'h34;
  localparam logic [7:0] A_PWR_REF    = 8'h38;
  localparam logic [7:0] A_BEEP       = 8'h3C;
  localparam logic [7:0] A_SELFTEST   = 8'h40;
  localparam logic [7:0] A_ZERO       = 8'h44;

  localparam int unsigned CMD_ARM_STORE  = 0;
  localparam int unsigned CMD_ARM_RETURN = 1;
  localparam int unsigned CMD_ONE_SHOT   = 2;
  localparam int unsigned CMD_CONFIGURE  = 3;
  localparam int unsigned CMD_FETCH      = 4;
  localparam int unsigned CMD_CLEAR      = 5;
  localparam int unsigned CMD_BUS_TRIG   = 6;
  localparam int unsigned CMD_SELF_TEST  = 7;

  localparam logic [7:0] ERR_NO_STORAGE = 8'h01;
  localparam logic [7:0] ERR_OVERFLOW   = 8'h02;
  localparam logic [7:0] ERR_RANGE      = 8'h03;

  typedef enum logic [1:0] {SRC_IMM, SRC_BUS, SRC_EXT} trs_src_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WAIT, ST_DELAY, ST_SAMPLE, ST_DUMP} trs_state_t;

endpackage

/* File: bench/trs_sequencer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module trs_sequencer_chk
  import trs_pkg::*;
#(
  parameter int unsigned RDG_W = 32
)
(
  // Clock, reset and register port
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  input  wire logic [31:0]      rdata,
  // Measurement path
  input  wire logic             rdg_valid,
  input  wire logic [RDG_W-1:0] rdg_data,
  input  wire logic             sample_req,
  input  wire logic             zero_req,
  input  wire logic             self_test_start,
  input  wire logic             math_valid,
  input  wire logic [RDG_W-1:0] math_data,
  // Panel levels
  input  wire logic             beep_enable,
  input  wire logic [4:0]       power_reference_resistance,
  input  wire logic [3:0]       panel_message_len
);
  logic       ref_wr;
  logic       msg_wr;
  logic [3:0] msg_exp;
  assign ref_wr  = wr && addr == A_PWR_REF;
  assign msg_wr  = wr && addr == A_MSG_LEN;
  assign msg_exp = wdata > 32'hC ? 4'hC : wdata[3:0];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_msg_write;
    msg_wr;
  endsequence
  sequence s_beep_write;
    wr && addr == A_BEEP;
  endsequence
  AST_RDATA_QUIET: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_MSG_CLAMP: assert property (panel_message_len <= 4'hC)
    else $error("message length above twelve");
  AST_MSG_SET: assert property (s_msg_write |=> panel_message_len == $past(msg_exp))
    else $error("message length not clamped");
  AST_MSG_HOLD: assert property (!$past(msg_wr) && !$past(rst) |-> $stable(panel_message_len))
    else $error("message length changed unasked");
  AST_REF_RANGE: assert property (power_reference_resistance < REF_COUNT)
    else $error("reference index out of list");
  AST_REF_HOLD: assert property (!$past(ref_wr) && !$past(rst)
    |-> $stable(power_reference_resistance))
    else $error("reference changed unasked");
  AST_BEEP_SET: assert property (s_beep_write |=> {31'h0, beep_enable} == ($past(wdata) & 32'h1))
    else $error("beeper enable not taken");
  AST_SAMPLE_PULSE: assert property (sample_req |=> !sample_req)
    else $error("sample request longer than one cycle");
  AST_MATH_EACH: assert property (rdg_valid |=> math_valid && math_data == $past(rdg_data))
    else $error("reading not passed to math");
  AST_ZERO_PULSE: assert property (zero_req |=> !zero_req)
    else $error("zero request longer than one cycle");
  AST_SELFTEST_PULSE: assert property (self_test_start |=> !self_test_start)
    else $error("self test start longer than one cycle");
endmodule
bind trs_sequencer trs_sequencer_chk #(.RDG_W(RDG_W)) u_chk (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .rdg_valid(rdg_valid), .rdg_data(rdg_data), .sample_req(sample_req), .zero_req(zero_req),
  .self_test_start(self_test_start), .math_valid(math_valid), .math_data(math_data),
  .beep_enable(beep_enable), .power_reference_resistance(power_reference_resistance),
  .panel_message_len(panel_message_len)
);
`default_nettype wire

/* File: bench/trs_meas_model.sv */
`timescale 1ns/1ps
`default_nettype none
module trs_meas_model
#(
  parameter int unsigned RDG_W = 32
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Requests and behaviour select
  input  wire logic             sample_req,
  input  wire logic             self_test_start,
  input  wire logic             slow,
  input  wire logic             fail_mode,
  // Answers
  output logic                  rdg_valid,
  output logic      [RDG_W-1:0] rdg_data,
  output logic                  self_test_done,
  output logic                  self_test_fail
);
  int               wait_cnt;
  int               st_cnt;
  logic [RDG_W-1:0] seq;
  // Data toggles outside the valid cycle so a stale word never looks fresh
  always_ff @(posedge mclk)
  begin
    rdg_valid      <= 1'b0;
    self_test_done <= 1'b0;
    rdg_data       <= ~rdg_data;
    if (rst)
    begin
      wait_cnt       <= 0;
      st_cnt         <= 0;
      seq            <= 'h1;
      rdg_data       <= '0;
      self_test_fail <= 1'b0;
    end
    else
    begin
      if (sample_req)
        wait_cnt <= slow ? 8 : 1;
      else if (wait_cnt > 1)
        wait_cnt <= wait_cnt - 1;
      else if (wait_cnt == 1)
      begin
        wait_cnt  <= 0;
        rdg_valid <= 1'b1;
        rdg_data  <= seq;
        seq       <= {seq[RDG_W-2:0], ~seq[RDG_W-1]};
      end
      if (self_test_start)
        st_cnt <= 6;
      else if (st_cnt > 0)
        st_cnt <= st_cnt - 1;
      if (st_cnt == 1)
      begin
        self_test_done <= 1'b1;
        self_test_fail <= fail_mode;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/trs_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module trs_sequencer_bench;
  import trs_pkg::*;
  localparam int SETUP = 50;
  logic        mclk, rst, wr, rd, ext_trig_pin, local_mode, local_trig, slow, fail_mode;
  logic        rdg_valid, self_test_done, self_test_fail, sample_req, zero_req;
  logic        self_test_start, math_valid, out_valid, beep_enable;
  logic [7:0]  addr;
  logic [15:0] auto_delay_ticks;
  logic [31:0] wdata, rdata, rdg_data, math_data, out_data, lfsr, d;
  logic [4:0]  power_reference_resistance;
  logic [3:0]  panel_message_len;
  int          error_cnt, cmp_count, n_samp, n_zero, i, j, k, s, t, n0, nz;
  int          msg_v[4] = '{5, 12, 13, 200};
  logic [31:0] q_rdg[$];
  logic [31:0] q_out[$];
  trs_sequencer #(.SETUP_CNT(SETUP), .TICK_CNT(4)) u_trs_sequencer (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_trig_pin(ext_trig_pin), .local_mode(local_mode), .local_trig(local_trig),
    .auto_delay_ticks(auto_delay_ticks), .rdg_valid(rdg_valid), .rdg_data(rdg_data),
    .self_test_done(self_test_done), .self_test_fail(self_test_fail),
    .sample_req(sample_req), .zero_req(zero_req), .self_test_start(self_test_start),
    .math_valid(math_valid), .math_data(math_data), .out_valid(out_valid),
    .out_data(out_data), .beep_enable(beep_enable), .panel_message_len(panel_message_len),
    .power_reference_resistance(power_reference_resistance));
  trs_meas_model u_trs_meas_model (
    .mclk(mclk), .rst(rst), .sample_req(sample_req), .self_test_start(self_test_start),
    .slow(slow), .fail_mode(fail_mode), .rdg_valid(rdg_valid), .rdg_data(rdg_data),
    .self_test_done(self_test_done), .self_test_fail(self_test_fail));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_r(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask
  task automatic rd_r(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cmd(input int unsigned c);
    wr_r(A_CMD, 32'h1 << c);
  endtask
  task automatic wait_idle;
    for (int w = 0; w < 3000; w++)
    begin
      rd_r(A_STATUS);
      if (d[2:0] == 3'h0)
        break;
    end
  endtask
  task automatic trig_lat;
    n0 = n_samp;
    cmd(CMD_BUS_TRIG);
    for (k = 0; k < 200 && n_samp == n0; k++)
      cyc(1);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    if (sample_req === 1'b1) n_samp++;
    if (zero_req === 1'b1) n_zero++;
    if (rdg_valid === 1'b1) q_rdg.push_back(rdg_data);
    if (out_valid === 1'b1) q_out.push_back(out_data);
  end
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    summarize();
  end
  initial
  begin
    {rst, wr, rd, addr, wdata} = {1'b1, 42'h0};
    {ext_trig_pin, local_mode, local_trig, slow, fail_mode} = 5'h0;
    {auto_delay_ticks, lfsr, error_cnt, cmp_count, n_samp, n_zero} = {16'h5, 32'h3D5DA115, 128'h0};
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    cyc(2);
    chk("beeper", 1, beep_enable);
    chk("reference", 32'hB, power_reference_resistance);
    rd_r(A_TRIG_SRC);
    chk("source", 0, d);
    rd_r(8'hFC);
    chk("unmapped", 0, d);
    foreach (msg_v[m])
    begin
      wr_r(A_MSG_LEN, msg_v[m]);
      cyc(1);
      chk("message", msg_v[m] > 12 ? 12 : msg_v[m], panel_message_len);
    end
    wr_r(A_BEEP, 0);
    cyc(1);
    chk("beeper off", 0, beep_enable);
    wr_r(A_ZERO, 1);
    for (i = 0; i < 2; i++)
    begin
      lfsr = lfsr_next(lfsr);
      s = 1 + lfsr[1:0] % 3;
      t = 1 + lfsr[3:2] % 3;
      slow <= lfsr[4];
      {nz, n0} = {n_zero, n_samp};
      q_rdg.delete();
      wr_r(A_SAMPLES, s);
      wr_r(A_TRIGS, t);
      cmd(CMD_ARM_STORE);
      wait_idle();
      rd_r(A_POINTS);
      chk("points", s * t, d);
      chk("samples", n0 + s * t, n_samp);
      chk("zeroes", nz + 1, n_zero);
      q_out.delete();
      cmd(CMD_FETCH);
      for (k = 0; k < 600 && q_out.size() < s * t; k++)
        cyc(1);
      foreach (q_rdg[r])
        chk("fetched", q_rdg[r], q_out[r]);
    end
    q_out.delete();
    cmd(CMD_ARM_RETURN);
    wait_idle();
    cyc(2);
    chk("direct", s * t, q_out.size());
    wr_r(A_FEED, 0);
    q_rdg.delete();
    cmd(CMD_ARM_STORE);
    wait_idle();
    rd_r(A_POINTS);
    chk("unstored", 0, d);
    chk("readings", s * t, q_rdg.size());
    cmd(CMD_FETCH);
    wr_r(A_PWR_REF, 17);
    wr_r(A_PWR_REF, 16);
    cyc(1);
    chk("reference", 16, power_reference_resistance);
    rd_r(A_ERR);
    chk("first error", ERR_NO_STORAGE, d[7:0]);
    rd_r(A_ERR);
    chk("second error", ERR_RANGE, d[7:0]);
    cmd(CMD_CONFIGURE);
    rd_r(A_FEED);
    chk("feed", 1, d);
    wr_r(A_HIGH_RANGE, 100);
    wr_r(A_LIM_HI, 120);
    wr_r(A_LIM_HI, 121);
    rd_r(A_LIM_HI);
    chk("upper bound", 120, d);
    rd_r(A_ERR);
    chk("limit error", ERR_RANGE, d[7:0]);
    wr_r(A_TRIG_SRC, 1);
    wr_r(A_SAMPLES, 1);
    wr_r(A_TRIGS, 1);
    wr_r(A_DELAY, 3);
    trig_lat();
    chk("idle trigger", n0, n_samp);
    cmd(CMD_ARM_RETURN);
    cyc(SETUP + 5);
    trig_lat();
    chk("delay", 1, k >= 12 && k < 40);
    wait_idle();
    wr_r(A_AUTO_DELAY, 1);
    cmd(CMD_ARM_RETURN);
    cyc(SETUP + 5);
    trig_lat();
    chk("auto delay", 1, k >= 20 && k < 50);
    wait_idle();
    wr_r(A_DELAY, 0);
    rd_r(A_AUTO_DELAY);
    chk("auto cleared", 0, d);
    wr_r(A_TRIG_SRC, 2);
    cmd(CMD_ARM_RETURN);
    n0 = n_samp;
    for (j = 0; j < 2; j++)
    begin
      @(posedge mclk);
      ext_trig_pin <= 1'b1;
      cyc(3);
      ext_trig_pin <= 1'b0;
      cyc(SETUP + 10);
      chk("external", n0 + j, n_samp);
    end
    wr_r(A_TRIG_SRC, 0);
    wr_r(A_TRIGS, 32'h80000001);
    n0 = n_samp;
    cmd(CMD_ARM_RETURN);
    cyc(SETUP + 200);
    chk("endless", 1, n_samp > n0 + 2);
    cmd(CMD_CLEAR);
    wait_idle();
    n0 = n_samp;
    cyc(50);
    chk("cleared", n0, n_samp);
    wr_r(A_TRIGS, 1);
    @(posedge mclk);
    {local_mode, local_trig} <= 2'b11;
    @(posedge mclk);
    local_trig <= 1'b0;
    cyc(40);
    chk("local", n0 + 1, n_samp);
    local_mode <= 1'b0;
    for (j = 0; j < 2; j++)
    begin
      fail_mode <= j[0];
      cmd(CMD_SELF_TEST);
      cyc(20);
      rd_r(A_SELFTEST);
      chk("self test", j, d[0]);
    end
    wr_r(A_SAMPLES, 513);
    cmd(CMD_ARM_STORE);
    wait_idle();
    rd_r(A_POINTS);
    chk("full memory", 512, d);
    rd_r(A_ERR);
    chk("overflow", ERR_OVERFLOW, d[7:0]);
    summarize();
  end
endmodule
`default_nettype wire
